// ===== hw/tmr_pkg.sv
// timer package: register map, control field layout, reset values, modes
// assumes a 32-bit ahb-lite register bus and one 10 mhz system clock
package tmr_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] TMR_CTRL_OFF   = 8'h00; // control word
    localparam logic [7:0] TMR_START_OFF  = 8'h04; // start count, writes load the counter
    localparam logic [7:0] TMR_RELOAD_OFF = 8'h08; // reload value
    localparam logic [7:0] TMR_PWM_OFF    = 8'h0c; // pwm match value
    localparam logic [7:0] TMR_COUNT_OFF  = 8'h10; // live count, read only
    localparam logic [7:0] TMR_IRQHI_OFF  = 8'h14; // interrupt enable high bits
    localparam logic [7:0] TMR_IRQLO_OFF  = 8'h18; // interrupt enable low bits
    localparam logic [7:0] TMR_STAT_OFF   = 8'h1c; // output and pin status, read only

    // ==========================================================
    // field positions and widths
    localparam int TMR_CTRL_W       = 10;   // used control bits
    localparam int TMR_IRQ_T1_BIT   = 6;    // timer 1 enable bit in irq regs
    localparam int TMR_IRQ_T0_BIT   = 5;    // timer 0 enable bit in irq regs
    localparam int TMR_STAT_OUT_BIT = 0;    // timer output level
    localparam int TMR_STAT_PIN_BIT = 1;    // synchronised pin level
    localparam int TMR_STAT_MAT_BIT = 2;    // pwm past-match flag

    // ==========================================================
    // reset and restart values
    localparam logic [15:0] TMR_RESTART_VAL = 16'h0001; // count after reload
    localparam logic [15:0] TMR_CNT_RST     = 16'h0001; // counter at reset
    localparam logic [15:0] TMR_RELOAD_RST  = 16'hffff; // reload at reset
    localparam logic [15:0] TMR_PWM_RST     = 16'h0000; // pwm match at reset
    localparam logic [7:0]  TMR_IRQ_RST     = 8'h00;    // irq enables at reset

    // ==========================================================
    // timer modes
    typedef enum logic [1:0] {
        TMR_ONESHOT = 2'h0,   // stop at reload
        TMR_CONT    = 2'h1,   // restart at reload
        TMR_PWM     = 2'h2,   // single output pwm
        TMR_RSVD    = 2'h3    // behaves as continuous
    } tmr_mode_t;

    // control word, bit 9 down to bit 0
    typedef struct packed {
        logic      gpio_data;           // pin level when alternate function off
        logic      pin_direction_bit;   // 1 input, 0 output
        logic      alt_en;              // timer output owns the pin
        logic [2:0] prescale;           // ratio is two to this power
        logic      output_polarity_bit; // output start level
        tmr_mode_t mode;                // operating mode
        logic      enable;              // counting on
    } tmr_ctrl_t;

    localparam tmr_ctrl_t TMR_CTRL_RST = '{gpio_data: 1'b0, pin_direction_bit: 1'b1,
        alt_en: 1'b0, prescale: 3'h0, output_polarity_bit: 1'b0, mode: TMR_ONESHOT,
        enable: 1'b0};

    // pin signals kept together
    typedef struct packed {
        logic o;    // driven level
        logic oe;   // drive enable
    } tmr_pin_t;

endpackage : tmr_pkg

// ===== hw/tmr_top.sv
// timer top: 16-bit up counter with one-shot, continuous and pwm modes,
// an ahb-lite register slave, the timer output pin and the irq request.
// assumes a single ahb-lite master, word transfers only, one clock domain.
//
// Operation
// - one-shot reload inverts output one cycle
// - one-shot counts only prescaled system clock
// - timeout is (reload minus start) times prescale ratio
// - continuous reload raises irq, restarts at 0001h
// - continuous reload toggles output pin level
// - pwm match inverts the timer output
// - pwm reload raises irq, restarts at 0001h
// - polarity one: high, low at match, high
// - alternate function overrides pin direction bit
// - irq enable high and low, bits 6/5
// - polarity zero: low, high at match, low
// - pwm start count only for first pass
`timescale 1ns/1ps
module tmr_top (
    input  wire logic        hclk,           // system clock, 10 mhz
    input  wire logic        hresetn,        // async reset, active low
    input  wire logic        hsel,           // slave select
    input  wire logic [31:0] haddr,          // byte address
    input  wire logic [1:0]  htrans,         // transfer type
    input  wire logic        hwrite,         // write when high
    input  wire logic [2:0]  hsize,          // word only
    input  wire logic [31:0] hwdata,         // write data
    input  wire logic        hready,         // bus ready in
    output logic      [31:0] hrdata,         // read data, registered
    output logic             hreadyout,      // always ready
    output logic             hresp,          // always okay
    input  wire logic        tout_pin_i,     // timer pin level from pad
    output tmr_pkg::tmr_pin_t tout_pin,      // timer pin level and enable
    output logic             timer_irq,      // reload request pulse
    output logic      [1:0]  timer_irq_prio, // {high, low} enable of this timer
    output logic      [1:0]  sibling_prio    // {high, low} enable of timer 1
);

    // ==========================================================
    // bus slave state
    logic        wr_pend_q, wr_pend_d;   // write data phase pending
    logic [7:0]  wr_addr_q, wr_addr_d;   // latched write offset
    logic [31:0] rdata_q,   rdata_d;     // read data for data phase
    logic        addr_ok;                // valid address phase
    logic        wr_ctrl, wr_start, wr_reload, wr_pwm, wr_hi, wr_lo; // write strobes

    // ==========================================================
    // timer state
    tmr_pkg::tmr_ctrl_t ctrl_q, ctrl_d;  // control word
    logic [15:0] cnt_q,    cnt_d;        // counter
    logic [15:0] reload_q, reload_d;     // reload value
    logic [15:0] pwm_q,    pwm_d;        // pwm match value
    logic [7:0]  irqhi_q,  irqhi_d;      // enable high bits
    logic [7:0]  irqlo_q,  irqlo_d;      // enable low bits
    logic [7:0]  presc_q,  presc_d;      // prescale divider
    logic        tgl_q,    tgl_d;        // continuous toggle state
    logic        match_q,  match_d;      // pwm past the match
    logic        pulse_q,  pulse_d;      // one-shot single-cycle inversion
    logic        irq_q,    irq_d;        // irq pulse
    tmr_pkg::tmr_pin_t pin_q, pin_d;     // registered pin drive
    logic        sync1_q, sync2_q;       // pin synchroniser
    logic [7:0]  presc_top;              // last divider value
    logic        tick;                   // prescaler terminal tick
    logic        reload_evt;             // count reaches reload
    logic        match_evt;              // count reaches pwm value
    logic        out_lvl;                // timer output level

    // ==========================================================
    // bus decode: zero wait state, reads sampled at address phase
    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign wr_ctrl   = wr_pend_q && (wr_addr_q == tmr_pkg::TMR_CTRL_OFF);
    assign wr_start  = wr_pend_q && (wr_addr_q == tmr_pkg::TMR_START_OFF);
    assign wr_reload = wr_pend_q && (wr_addr_q == tmr_pkg::TMR_RELOAD_OFF);
    assign wr_pwm    = wr_pend_q && (wr_addr_q == tmr_pkg::TMR_PWM_OFF);
    assign wr_hi     = wr_pend_q && (wr_addr_q == tmr_pkg::TMR_IRQHI_OFF);
    assign wr_lo     = wr_pend_q && (wr_addr_q == tmr_pkg::TMR_IRQLO_OFF);

    // next bus state and read mux; unmapped offsets read zero
    always_comb begin
        wr_pend_d = addr_ok && hwrite;
        wr_addr_d = wr_addr_q;
        rdata_d   = 32'h0000_0000;
        if (addr_ok) begin
            wr_addr_d = haddr[7:0];
        end
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                tmr_pkg::TMR_CTRL_OFF:   rdata_d = {22'h000000, ctrl_q};
                tmr_pkg::TMR_START_OFF:  rdata_d = {16'h0000, cnt_q};
                tmr_pkg::TMR_RELOAD_OFF: rdata_d = {16'h0000, reload_q};
                tmr_pkg::TMR_PWM_OFF:    rdata_d = {16'h0000, pwm_q};
                tmr_pkg::TMR_COUNT_OFF:  rdata_d = {16'h0000, cnt_q};
                tmr_pkg::TMR_IRQHI_OFF:  rdata_d = {24'h000000, irqhi_q};
                tmr_pkg::TMR_IRQLO_OFF:  rdata_d = {24'h000000, irqlo_q};
                tmr_pkg::TMR_STAT_OFF: begin
                    rdata_d[tmr_pkg::TMR_STAT_OUT_BIT] = out_lvl;
                    rdata_d[tmr_pkg::TMR_STAT_PIN_BIT] = sync2_q;
                    rdata_d[tmr_pkg::TMR_STAT_MAT_BIT] = match_q;
                end
                default:                 rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q   <= rdata_d;
        end
    end

    // ==========================================================
    // pin synchroniser: first stage read only by the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= tout_pin_i;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // prescaler: system clock is the only count source, no pin input
    assign presc_top  = 8'((9'h001 << ctrl_q.prescale) - 9'h001);
    assign tick       = ctrl_q.enable && (presc_q == presc_top);
    // events fire as the count arrives, so a pass takes reload-start ticks
    assign reload_evt = tick && (16'(cnt_q + 16'h0001) == reload_q);
    assign match_evt  = tick && (ctrl_q.mode == tmr_pkg::TMR_PWM)
                        && (16'(cnt_q + 16'h0001) == pwm_q);
    assign out_lvl    = ctrl_q.output_polarity_bit ^ tgl_q ^ match_q ^ pulse_q;

    // ==========================================================
    // timer next state
    always_comb begin
        ctrl_d   = ctrl_q;
        cnt_d    = cnt_q;
        reload_d = reload_q;
        pwm_d    = pwm_q;
        irqhi_d  = irqhi_q;
        irqlo_d  = irqlo_q;
        presc_d  = presc_q;
        tgl_d    = tgl_q;
        match_d  = match_q;
        pulse_d  = 1'b0;
        irq_d    = reload_evt;
        // prescaler runs only while enabled, restarts from zero
        if (!ctrl_q.enable) begin
            presc_d = 8'h00;
        end else if (tick) begin
            presc_d = 8'h00;
        end else begin
            presc_d = 8'(presc_q + 8'h01);
        end
        // counting
        if (reload_evt) begin
            cnt_d = tmr_pkg::TMR_RESTART_VAL;
            case (ctrl_q.mode)
                tmr_pkg::TMR_ONESHOT: begin
                    ctrl_d.enable = 1'b0;   // one pass, then stop
                    pulse_d       = 1'b1;
                end
                tmr_pkg::TMR_PWM: begin
                    match_d = 1'b0;         // back to start level
                end
                default: begin
                    tgl_d = !tgl_q;
                end
            endcase
        end else if (tick) begin
            cnt_d = 16'(cnt_q + 16'h0001);
        end
        if (match_evt && !reload_evt) begin
            match_d = 1'b1;
        end
        // software writes win over the hardware stop
        if (wr_ctrl) begin
            ctrl_d = tmr_pkg::tmr_ctrl_t'(hwdata[tmr_pkg::TMR_CTRL_W-1:0]);
            // a running one-shot keeps its pin level when the polarity flips,
            // so the time-out inversion becomes a lasting level change
            if (ctrl_q.enable && (ctrl_q.mode == tmr_pkg::TMR_ONESHOT)
                && !reload_evt) begin
                tgl_d = tgl_q ^ ctrl_d.output_polarity_bit ^ ctrl_q.output_polarity_bit;
            end
        end
        if (wr_start) begin
            cnt_d = hwdata[15:0];   // first pass only; every mode restarts at 0001h
        end
        if (wr_reload) begin
            reload_d = hwdata[15:0];
        end
        if (wr_pwm) begin
            pwm_d = hwdata[15:0];
        end
        if (wr_hi) begin
            irqhi_d = hwdata[7:0] & 8'h60;
        end
        if (wr_lo) begin
            irqlo_d = hwdata[7:0] & 8'h60;
        end
        // a stopped timer forgets its output phase
        if (!ctrl_q.enable && !reload_evt) begin
            tgl_d   = 1'b0;
            match_d = 1'b0;
        end
        // pin: alternate function owns it whatever the direction bit says
        if (ctrl_d.alt_en) begin
            pin_d.o  = ctrl_d.output_polarity_bit ^ tgl_d ^ match_d ^ pulse_d;
            pin_d.oe = 1'b1;
        end else begin
            pin_d.o  = ctrl_d.gpio_data;
            pin_d.oe = !ctrl_d.pin_direction_bit;
        end
    end

    // timer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= tmr_pkg::TMR_CTRL_RST;
            cnt_q    <= tmr_pkg::TMR_CNT_RST;
            reload_q <= tmr_pkg::TMR_RELOAD_RST;
            pwm_q    <= tmr_pkg::TMR_PWM_RST;
            irqhi_q  <= tmr_pkg::TMR_IRQ_RST;
            irqlo_q  <= tmr_pkg::TMR_IRQ_RST;
            presc_q  <= 8'h00;
            tgl_q    <= 1'b0;
            match_q  <= 1'b0;
            pulse_q  <= 1'b0;
            irq_q    <= 1'b0;
            pin_q    <= '{o: 1'b0, oe: 1'b0};
        end else begin
            ctrl_q   <= ctrl_d;
            cnt_q    <= cnt_d;
            reload_q <= reload_d;
            pwm_q    <= pwm_d;
            irqhi_q  <= irqhi_d;
            irqlo_q  <= irqlo_d;
            presc_q  <= presc_d;
            tgl_q    <= tgl_d;
            match_q  <= match_d;
            pulse_q  <= pulse_d;
            irq_q    <= irq_d;
            pin_q    <= pin_d;
        end
    end

    // ==========================================================
    // outputs; the controller decides priority from the two enables
    assign tout_pin       = pin_q;
    assign timer_irq      = irq_q;
    assign timer_irq_prio = {irqhi_q[tmr_pkg::TMR_IRQ_T0_BIT],
                             irqlo_q[tmr_pkg::TMR_IRQ_T0_BIT]};
    assign sibling_prio   = {irqhi_q[tmr_pkg::TMR_IRQ_T1_BIT],
                             irqlo_q[tmr_pkg::TMR_IRQ_T1_BIT]};

    // ==========================================================
    // assertions
    a_irq_after_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        reload_evt |=> timer_irq)
        else $error("reload without irq pulse");

    a_irq_needs_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_irq |-> $past(reload_evt))
        else $error("irq pulse without reload");

    a_restart_value: assert property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && !wr_start |=> cnt_q == 16'h0001)
        else $error("count did not restart at 0001h");

    a_count_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q.enable && !wr_start |=> $stable(cnt_q))
        else $error("count moved while disabled");

    a_step_by_tick: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && !reload_evt && !wr_start |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
        else $error("count did not step on tick");

    a_oneshot_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && ctrl_q.mode == tmr_pkg::TMR_ONESHOT && ctrl_q.alt_en && !wr_ctrl
        |=> tout_pin.o != $past(tout_pin.o) ##1 tout_pin.o == ctrl_q.output_polarity_bit)
        else $error("one-shot output not a single cycle inversion");

    a_oneshot_stops: assert property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && ctrl_q.mode == tmr_pkg::TMR_ONESHOT && !wr_ctrl |=> !ctrl_q.enable)
        else $error("one-shot kept counting");

    a_cont_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && ctrl_q.mode == tmr_pkg::TMR_CONT && ctrl_q.alt_en && !wr_ctrl
        |=> tout_pin.o != $past(tout_pin.o))
        else $error("continuous reload did not toggle the pin");

    a_pwm_match_lvl: assert property (@(posedge hclk) disable iff (!hresetn)
        match_evt && !reload_evt && ctrl_q.alt_en && !wr_ctrl
        |=> tout_pin.o == !ctrl_q.output_polarity_bit)
        else $error("pwm output wrong after match");

    a_pwm_reload_lvl: assert property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && ctrl_q.mode == tmr_pkg::TMR_PWM && ctrl_q.alt_en && !wr_ctrl
        |=> tout_pin.o == ctrl_q.output_polarity_bit)
        else $error("pwm output wrong after reload");

    a_alt_owns_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q.alt_en |-> tout_pin.oe)
        else $error("alternate function not driving pin");

    a_gpio_owns_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q.alt_en |-> tout_pin.oe == !ctrl_q.pin_direction_bit)
        else $error("pin drive does not follow the direction bit");

    a_prescale_gap: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && ctrl_q.prescale == 3'h2 && !reload_evt && !wr_ctrl
        |=> !tick [*3] ##1 tick)
        else $error("prescale ratio four not kept");

    c_oneshot_done: cover property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && ctrl_q.mode == tmr_pkg::TMR_ONESHOT);
    c_cont_reload: cover property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && ctrl_q.mode == tmr_pkg::TMR_CONT);
    c_pwm_cycle: cover property (@(posedge hclk) disable iff (!hresetn)
        match_evt ##[1:300] reload_evt);
    c_irq_enabled: cover property (@(posedge hclk) disable iff (!hresetn)
        timer_irq && timer_irq_prio != 2'h0);
    c_oneshot_lasting: cover property (@(posedge hclk) disable iff (!hresetn)
        reload_evt && ctrl_q.mode == tmr_pkg::TMR_ONESHOT && tgl_q);

endmodule : tmr_top

// ===== verification/tmr_pad_model.sv
// tmr_pad_model: the circuit outside the timer pin, a pad with a pull-up
// assumes the timer drives the pad only while its enable is high
`timescale 1ns/1ps
module tmr_pad_model (
    input  wire logic pin_o,  // level the timer drives
    input  wire logic pin_oe, // drive enable, high drives
    output logic      pad     // resolved pad level
);
    // ==========================================================
    // pad resolution
    // a released pin is pulled up, so a stale drive value never shows
    assign pad = pin_oe ? pin_o : 1'b1;
endmodule : tmr_pad_model

// ===== verification/testbench.sv
// testbench: self-checking bench for the timer, an ahb-lite master in tasks
// assumes tmr_top with zero wait states and the pull-up pad model
`timescale 1ns/1ps
module testbench;
    logic              hclk;           // 10 mhz clock
    logic              hresetn;        // async reset, active low
    logic              hsel;           // slave select
    logic              hwrite;         // write when high
    logic       [31:0] haddr;          // byte address
    logic       [31:0] hwdata;         // write data
    logic       [31:0] hrdata;         // read data
    logic       [31:0] rd;             // last bus read
    logic       [1:0]  htrans;         // transfer type
    logic       [2:0]  hsize;          // always word
    logic              hreadyout;      // slave ready
    logic              hresp;          // slave response
    logic              pad;            // resolved pin level
    logic              timer_irq;      // reload pulse
    logic       [1:0]  timer_irq_prio; // this timer's enables
    logic       [1:0]  sibling_prio;   // timer 1 enables
    tmr_pkg::tmr_pin_t tout_pin;       // timer pin drive
    int                n_errors;       // mismatches
    int                cmp_count;      // comparisons
    int                cyc;            // cycles run
    int                n;              // measured cycles

    // ==========================================================
    // design and pad
    tmr_top tmr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tout_pin_i(pad), .tout_pin(tout_pin), .timer_irq(timer_irq),
        .timer_irq_prio(timer_irq_prio), .sibling_prio(sibling_prio));
    tmr_pad_model tmr_pad_model_i (.pin_o(tout_pin.o), .pin_oe(tout_pin.oe), .pad(pad));

    // ==========================================================
    // clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // whole run is a few hundred cycles, so this only trips on a hang
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one single transfer; a fresh edge first, so back-to-back calls idle once
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rc
    // control word with the pin direction left as input
    function automatic logic [31:0] cw(logic en, logic [1:0] md, logic pol, logic [2:0] pre);
        return {22'h0, 1'b0, 1'b1, 1'b1, pre, pol, md, en};
    endfunction : cw
    // cycles from now until the reload pulse is seen
    task automatic wait_irq(output int k);
        k = 0;
        do begin
            @(posedge hclk);
            #1;
            k++;
        end while (timer_irq !== 1'b1 && k < 3000);
    endtask : wait_irq

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk("oe", 32'(tout_pin.oe), 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
        chk("hreadyout", 32'(hreadyout), 32'h1);
        rc("ctrl", tmr_pkg::TMR_CTRL_OFF, 32'h100);
        rc("reload", tmr_pkg::TMR_RELOAD_OFF, 32'hffff);
        rc("count", tmr_pkg::TMR_COUNT_OFF, 32'h1);
        rc("unmapped", 8'h20, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_regs();
        bus(1'b1, tmr_pkg::TMR_IRQHI_OFF, 32'hff);
        bus(1'b1, tmr_pkg::TMR_IRQLO_OFF, 32'h20);
        rc("irqhi", tmr_pkg::TMR_IRQHI_OFF, 32'h60);
        rc("irqlo", tmr_pkg::TMR_IRQLO_OFF, 32'h20);
        chk("t0 prio", 32'(timer_irq_prio), 32'h3);
        chk("t1 prio", 32'(sibling_prio), 32'h2);
        bus(1'b1, tmr_pkg::TMR_START_OFF, 32'h123);
        repeat (10) @(posedge hclk);
        rc("held count", tmr_pkg::TMR_COUNT_OFF, 32'h123);
        $display("register test done");
    endtask : t_regs
    task automatic t_pin();
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, 32'h0);
        repeat (3) @(posedge hclk);
        rc("gpio out", tmr_pkg::TMR_STAT_OFF, 32'h0);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, 32'h100);
        repeat (3) @(posedge hclk);
        rc("gpio in", tmr_pkg::TMR_STAT_OFF, 32'h2);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b0, 2'h0, 1'b1, 3'h0));
        repeat (2) @(posedge hclk);
        #1;
        chk("alt oe", 32'(tout_pin.oe), 32'h1);
        chk("alt o", 32'(tout_pin.o), 32'h1);
        $display("pin test done");
    endtask : t_pin
    task automatic t_oneshot();
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b0, 2'h0, 1'b0, 3'h2));
        bus(1'b1, tmr_pkg::TMR_START_OFF, 32'h10);
        bus(1'b1, tmr_pkg::TMR_RELOAD_OFF, 32'h14);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b1, 2'h0, 1'b0, 3'h2));
        wait_irq(n);
        chk("oneshot time", 32'(n), 32'd16);
        chk("oneshot pulse", 32'(tout_pin.o), 32'h1);
        @(posedge hclk);
        #1;
        chk("oneshot end", 32'(tout_pin.o), 32'h0);
        chk("irq width", 32'(timer_irq), 32'h0);
        rc("oneshot stop", tmr_pkg::TMR_CTRL_OFF, cw(1'b0, 2'h0, 1'b0, 3'h2));
        // lasting change: start low, flip the polarity once running
        bus(1'b1, tmr_pkg::TMR_START_OFF, 32'h10);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b1, 2'h0, 1'b0, 3'h2));
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b1, 2'h0, 1'b1, 3'h2));
        #1;
        chk("lasting hold", 32'(tout_pin.o), 32'h0);
        wait_irq(n);
        chk("lasting time", 32'(n), 32'd13);
        chk("lasting edge", 32'(tout_pin.o), 32'h1);
        repeat (3) @(posedge hclk);
        #1;
        chk("lasting level", 32'(tout_pin.o), 32'h1);
        $display("one-shot test done");
    endtask : t_oneshot
    task automatic t_cont();
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b0, 2'h1, 1'b0, 3'h0));
        bus(1'b1, tmr_pkg::TMR_START_OFF, 32'h1);
        bus(1'b1, tmr_pkg::TMR_RELOAD_OFF, 32'h6);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b1, 2'h1, 1'b0, 3'h0));
        wait_irq(n);
        chk("cont first", 32'(n), 32'd5);
        chk("cont toggle", 32'(tout_pin.o), 32'h1);
        @(posedge hclk);
        #1;
        chk("irq width", 32'(timer_irq), 32'h0);
        wait_irq(n);
        chk("cont period", 32'(n), 32'd4);
        chk("cont toggle", 32'(tout_pin.o), 32'h0);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b0, 2'h1, 1'b0, 3'h0));
        $display("continuous test done");
    endtask : t_cont
    task automatic t_pwm(input logic pol);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b0, 2'h2, pol, 3'h0));
        bus(1'b1, tmr_pkg::TMR_START_OFF, 32'h4);
        bus(1'b1, tmr_pkg::TMR_PWM_OFF, 32'h3);
        bus(1'b1, tmr_pkg::TMR_RELOAD_OFF, 32'h6);
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b1, 2'h2, pol, 3'h0));
        wait_irq(n);
        chk("pwm first", 32'(n), 32'd2);
        chk("pwm start", 32'(tout_pin.o), 32'(pol));
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (tout_pin.o === pol && n < 50);
        chk("pwm match", 32'(n), 32'd2);
        wait_irq(n);
        chk("pwm reload", 32'(n), 32'd3);
        chk("pwm back", 32'(tout_pin.o), 32'(pol));
        bus(1'b1, tmr_pkg::TMR_CTRL_OFF, cw(1'b0, 2'h2, pol, 3'h0));
        $display("pwm test done");
    endtask : t_pwm

    // ==========================================================
    // closing report, the only place the run ends
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // ==========================================================
    // main sequence
    initial begin
        n_errors  = 0;
        cmp_count = 0;
        cyc       = 0;
        hresetn   = 1'b0;
        hsel      = 1'b0;
        hwrite    = 1'b0;
        haddr     = 32'h0;
        hwdata    = 32'h0;
        htrans    = 2'h0;
        hsize     = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_regs();
        t_pin();
        t_oneshot();
        t_cont();
        t_pwm(1'b1);
        t_pwm(1'b0);
        end_sim();
    end
endmodule : testbench
